//--- hw/amp_interrupt_status_control.sv
// Interrupt status and control block of a smart audio amplifier, with the
// two SAR control fields it carries, reached over a 32-bit APB slave.
// Assumes event detectors outside the pclk domain and SAR data from
// logic on pclk.
//
// How it works
// - Each of the seven sources has a disable bit, where 1 stops its interrupt and 0 allows it.
// - Writing 1 to a status bit 6..0 clears that flag and writing 0 leaves it alone.
// - Reading the status register returns all seven flags in bits 6..0.
// - Status bit 6 is the watchdog event and bit 5 is DSP outbound data valid.
// - Status bit 4 is the emergency shutdown event and bit 3 is the clip event.
// - Status bit 2 is low supply, bit 1 is over-voltage and bit 0 is power-up.
// - With the SAR invert bit at 1 the SAR output is inverted, at 0 it passes unchanged.
// - Each source also has a mask bit, where 1 blocks it from the interrupt and 0 lets it pass.
`timescale 1ns/100ps
`default_nettype none

module amp_interrupt_status_control
  import amp_irq_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int SAR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [SRC_COUNT-1:0] event_in,
  input wire logic [SAR_W-1:0] sar_data_in,
  output logic [SAR_W-1:0] sar_data_out,
  output logic sar_output_invert,
  output logic [GAIN_W-1:0] sar_gain_tracking,
  output logic irq
);

  // ---------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------
  generate
    if (ADDR_W < INDEX_W + INDEX_LSB) begin : g_bad_addr
      $error("ADDR_W too small to reach every register");
    end
    if (SAR_W < 1) begin : g_bad_sar
      $error("SAR_W must be at least one");
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Address decode helpers
  // ---------------------------------------------------------------------
  // Word index of a byte address.
  function automatic logic [INDEX_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = addr[INDEX_LSB +: INDEX_W];
  endfunction

  // True when the address names an implemented register.
  function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
    logic hit;
    hit = 1'b0;
    if (addr[INDEX_LSB-1:0] == '0 && (addr >> (INDEX_W + INDEX_LSB)) == '0) begin
      case (reg_index(addr))
        IDX_IRQ_DISABLE, IDX_IRQ_STATUS, IDX_SAR_CONTROL_ONE, IDX_IRQ_MASK: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
    reg_mapped = hit;
  endfunction

  // True when the access hits the given register.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    reg_hit = reg_mapped(addr) && (reg_index(addr) == idx);
  endfunction

  // ---------------------------------------------------------------------
  // APB response state
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } apb_state_t;

  apb_state_t state;
  apb_state_t next_state;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;
  logic commit;
  logic [15:0] wmask;
  logic [15:0] wbits;
  logic [15:0] read_value;

  logic [15:0] irq_disable;
  logic [15:0] irq_mask;
  logic [15:0] sar_control_one;
  logic [15:0] next_irq_disable;
  logic [15:0] next_irq_mask;
  logic [15:0] next_sar_control_one;
  logic [SRC_COUNT-1:0] flags;
  logic [SRC_COUNT-1:0] event_level;
  logic [SRC_COUNT-1:0] clr_vec;
  logic [SAR_W-1:0] next_sar_data_out;
  logic next_irq;

  // A write or a read finishes at the edge where pready is sampled high.
  assign commit = (state == ST_RESP) && psel && penable && pready;
  assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wbits = pwdata[15:0] & wmask;

  // Read multiplexer; disable, mask and status bits above bit 6 read as zero, SAR control reads all 16 bits.
  always_comb begin
    read_value = 16'h0000;
    if (reg_mapped(paddr)) begin
      case (reg_index(paddr))
        IDX_IRQ_DISABLE: read_value = irq_disable & SRC_FIELD;
        IDX_IRQ_STATUS: read_value = {{(REG_W - SRC_COUNT){1'b0}}, flags};
        IDX_SAR_CONTROL_ONE: read_value = sar_control_one;
        IDX_IRQ_MASK: read_value = irq_mask & SRC_FIELD;
        default: read_value = 16'h0000;
      endcase
    end
  end

  // Slave answers one cycle after the access phase starts; data and error
  // are loaded together with pready so all three come from flip-flops.
  always_comb begin
    next_state = state;
    next_pready = 1'b0;
    next_pslverr = pslverr;
    next_prdata = prdata;
    case (state)
      ST_IDLE: begin
        if (psel && penable) begin
          next_state = ST_RESP;
          next_pready = 1'b1;
          next_pslverr = !reg_mapped(paddr);
          next_prdata = pwrite ? 32'h0000_0000 : {16'h0000, read_value};
        end
      end
      ST_RESP: begin
        next_state = ST_IDLE;
        next_pslverr = 1'b0;
      end
      default: begin
        next_state = ST_IDLE;
        next_pslverr = 1'b0;
      end
    endcase
  end

  // Registers the bus response.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      state <= next_state;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // ---------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------
  // Byte-lane writes take effect only on the completing edge.
  always_comb begin
    next_irq_disable = irq_disable;
    next_irq_mask = irq_mask;
    next_sar_control_one = sar_control_one;
    if (commit && pwrite) begin
      if (reg_hit(paddr, IDX_IRQ_DISABLE)) begin
        next_irq_disable = ((irq_disable & ~wmask) | wbits) & SRC_FIELD;
      end
      if (reg_hit(paddr, IDX_IRQ_MASK)) begin
        next_irq_mask = ((irq_mask & ~wmask) | wbits) & SRC_FIELD;
      end
      if (reg_hit(paddr, IDX_SAR_CONTROL_ONE)) begin
        next_sar_control_one = (sar_control_one & ~wmask) | wbits;
      end
    end
  end

  // Holds the control registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_disable <= IRQ_DISABLE_RESET;
      irq_mask <= IRQ_MASK_RESET;
      sar_control_one <= SAR_CONTROL_ONE_RESET;
    end else if (ce) begin
      irq_disable <= next_irq_disable;
      irq_mask <= next_irq_mask;
      sar_control_one <= next_sar_control_one;
    end
  end

  // ---------------------------------------------------------------------
  // Event flags
  // ---------------------------------------------------------------------
  // Ones written to the status word clear flags; zeros leave them.
  always_comb begin
    clr_vec = '0;
    if (commit && pwrite && reg_hit(paddr, IDX_IRQ_STATUS)) begin
      clr_vec = wbits[SRC_COUNT-1:0];
    end
  end

  // Flag k is driven by event_in[k]: watchdog 6 down to power-up 0.
  irq_flag_bank #(
    .N(SRC_COUNT)
  ) u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .event_raw(event_in),
    .clear(clr_vec),
    .flags(flags),
    .event_level(event_level)
  );

  // ---------------------------------------------------------------------
  // Interrupt and SAR outputs
  // ---------------------------------------------------------------------
  // Interrupt is raised by a set flag that is neither disabled nor masked.
  always_comb begin
    next_irq = |(flags & ~irq_disable[SRC_COUNT-1:0] & ~irq_mask[SRC_COUNT-1:0]);
    next_sar_data_out = sar_data_in ^ {SAR_W{sar_control_one[SAR_INVERT_BIT]}};
  end

  // Registers the interrupt and the SAR data path.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      sar_data_out <= '0;
    end else if (ce) begin
      irq <= next_irq;
      sar_data_out <= next_sar_data_out;
    end
  end

  // Field outputs come straight from the SAR control flip-flops.
  assign sar_output_invert = sar_control_one[SAR_INVERT_BIT];
  assign sar_gain_tracking = sar_control_one[SAR_GAIN_LSB +: GAIN_W];

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // A status write that completes on this edge.
  sequence seq_status_write;
    commit && pwrite && reg_hit(paddr, IDX_IRQ_STATUS);
  endsequence

  // A status read that enters its answer on this edge.
  sequence seq_status_read;
    ce && state == ST_IDLE && psel && penable && !pwrite && reg_hit(paddr, IDX_IRQ_STATUS);
  endsequence

  AST_IRQ_GATED: assert property (
    ce && (flags & ~irq_disable[SRC_COUNT-1:0] & ~irq_mask[SRC_COUNT-1:0]) == '0 |=> !irq
  ) else $error("interrupt high with no enabled unmasked flag");

  AST_MASK_BLOCKS: assert property (
    ce && (flags & ~irq_mask[SRC_COUNT-1:0]) == '0 |=> !irq
  ) else $error("masked flags still raise the interrupt");

  AST_IRQ_RAISED: assert property (
    ce && |(flags & ~irq_disable[SRC_COUNT-1:0] & ~irq_mask[SRC_COUNT-1:0]) |=> irq
  ) else $error("interrupt low while an enabled unmasked flag is set");

  AST_W1C_CLEAR: assert property (
    seq_status_write ##0 (ce && pstrb[0] && pwdata[BIT_CLIP] && !event_level[BIT_CLIP])
    |=> !flags[BIT_CLIP]
  ) else $error("writing one did not clear the clip flag");

  AST_FLAG_STICKY: assert property (
    ce |=> ((~flags & $past(flags)) & ~$past(clr_vec)) == '0
  ) else $error("a flag fell without a one written to it");

  AST_READ_STATUS: assert property (
    seq_status_read |=> pready && prdata == {25'h0, $past(flags)} ##1 (!pready || !$past(ce))
  ) else $error("status read returned wrong data or timing");

  AST_WATCHDOG_BIT: assert property (
    ce && event_level[BIT_WATCHDOG] |=> flags[BIT_WATCHDOG]
  ) else $error("watchdog event did not set status bit six");

  AST_SHUTDOWN_BIT: assert property (
    ce && event_level[BIT_EMERGENCY_SHUTDOWN] |=> flags[BIT_EMERGENCY_SHUTDOWN]
  ) else $error("shutdown event did not set status bit four");

  AST_POWERUP_BIT: assert property (
    ce && event_level[BIT_POWERUP] |=> flags[BIT_POWERUP]
  ) else $error("power-up event did not set status bit zero");

  AST_SAR_INVERT: assert property (
    ce |=> sar_data_out == ($past(sar_control_one[SAR_INVERT_BIT]) ?
                            ~$past(sar_data_in) : $past(sar_data_in))
  ) else $error("SAR output polarity does not follow the invert bit");

endmodule

`default_nettype wire

//--- hw/amp_irq_pkg.sv
// Package of register indices, field positions and reset values for the
// amplifier interrupt status and control block.
// Assumes a 32-bit APB slave that places each 16-bit register in one word.
package amp_irq_pkg;

  // ---------------------------------------------------------------------
  // Register geometry
  // ---------------------------------------------------------------------
  localparam int REG_W = 16;
  localparam int SRC_COUNT = 7;
  localparam int INDEX_W = 8;
  localparam int INDEX_LSB = 2;
  localparam int GAIN_W = 3;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_IRQ_DISABLE = 8'h05;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h06;
  localparam logic [7:0] IDX_SAR_CONTROL_ONE = 8'h07;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h20;

  // ---------------------------------------------------------------------
  // Event bit positions, shared by status, disable and mask registers
  // ---------------------------------------------------------------------
  localparam int BIT_WATCHDOG = 6;
  localparam int BIT_DSP_OUTBOUND = 5;
  localparam int BIT_EMERGENCY_SHUTDOWN = 4;
  localparam int BIT_CLIP = 3;
  localparam int BIT_LOW_SUPPLY = 2;
  localparam int BIT_OVERVOLTAGE = 1;
  localparam int BIT_POWERUP = 0;

  // ---------------------------------------------------------------------
  // SAR control fields
  // ---------------------------------------------------------------------
  localparam int SAR_INVERT_BIT = 15;
  localparam int SAR_GAIN_LSB = 12;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [15:0] IRQ_DISABLE_RESET = 16'h007f;
  localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;
  localparam logic [15:0] SAR_CONTROL_ONE_RESET = 16'h10b4;
  localparam logic [15:0] SRC_FIELD = 16'h007f;

endpackage

//--- hw/irq_flag_bank.sv
// Sticky event flags with input synchronisers, one slice per event source.
// Assumes event inputs come from outside the pclk domain and that clears
// arrive as one-cycle pulses from the register logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

module irq_flag_bank #(
  parameter int N = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [N-1:0] event_raw,
  input wire logic [N-1:0] clear,
  output logic [N-1:0] flags,
  output logic [N-1:0] event_level
);

  // ---------------------------------------------------------------------
  // Per-source slices
  // ---------------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < N; k++) begin : g_src
      logic sync_a;
      logic sync_b;
      logic flag;
      logic next_flag;

      // A new event wins over a clear in the same cycle so it is never lost.
      always_comb begin
        next_flag = (flag & ~clear[k]) | sync_b;
      end

      // Two-stage synchroniser and the sticky flag, frozen while ce is low.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_a <= 1'b0;
          sync_b <= 1'b0;
          flag <= 1'b0;
        end else if (ce) begin
          sync_a <= event_raw[k];
          sync_b <= sync_a;
          flag <= next_flag;
        end
      end

      assign flags[k] = flag;
      assign event_level[k] = sync_b;
    end
  endgenerate

endmodule

`default_nettype wire

//--- testbench/testbench.sv
// Self-checking testbench for the amplifier interrupt status and control block.
// Assumes the APB answer timing, event latency and reset values of the design.
`timescale 1ns/100ps
`default_nettype none

module testbench import amp_irq_pkg::*;;

  // ---------------------------------------------------------------------
  // Signals and design instance
  // ---------------------------------------------------------------------
  localparam logic [11:0] A_DIS = {2'b00, IDX_IRQ_DISABLE, 2'b00};
  localparam logic [11:0] A_STA = {2'b00, IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] A_SAR = {2'b00, IDX_SAR_CONTROL_ONE, 2'b00};
  localparam logic [11:0] A_MSK = {2'b00, IDX_IRQ_MASK, 2'b00};

  logic pclk = 1'b0;
  logic presetn;
  logic ce;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [6:0] event_in;
  logic [7:0] sar_data_in;
  logic [7:0] sar_data_out;
  logic sar_output_invert;
  logic [2:0] sar_gain_tracking;
  logic irq;
  int fails = 0;
  int compares = 0;
  logic [31:0] d;
  logic e;
  logic [6:0] ev;

  amp_interrupt_status_control amp_interrupt_status_control_inst (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_in(event_in),
    .sar_data_in(sar_data_in), .sar_data_out(sar_data_out),
    .sar_output_invert(sar_output_invert), .sar_gain_tracking(sar_gain_tracking),
    .irq(irq)
  );

  // The clock toggles every 5 ns, a period of 10 ns.
  always #5 pclk = ~pclk;

  // ---------------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------------
  // One APB transfer; the request is held until pready is sampled high.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] rdat;
    logic err;
    bus(1'b1, a, wd, rdat, err);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    logic err;
    bus(1'b0, a, 32'h0, v, err);
  endtask

  task automatic check32(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check1(input string what, input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic end_of_test;
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  // Resets the block, then walks through registers, events, gating and SAR.
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    event_in = 7'h00;
    sar_data_in = 8'h5a;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_DIS, d);
    check32("disable reset", d, 32'h0000_007f);
    rd(A_MSK, d);
    check32("mask reset", d, 32'h0);
    rd(A_STA, d);
    check32("status reset", d, 32'h0);
    check1("irq reset", irq, 1'b0);
    // Each source alone: its flag shows in its own bit, disabled from irq.
    for (int k = 0; k < 7; k++) begin
      ev = 7'h00;
      ev[k] = 1'b1;
      event_in <= ev;
      repeat (5) @(posedge pclk);
      event_in <= 7'h00;
      rd(A_STA, d);
      check32("flag bit", d, {25'h0, ev});
      check1("irq disabled", irq, 1'b0);
      wr(A_STA, 32'h0);
      rd(A_STA, d);
      check32("zero write", d, {25'h0, ev});
      wr(A_STA, {25'h0, ev});
      rd(A_STA, d);
      check32("one write", d, 32'h0);
    end
    // Enable all, then gate with the mask and the disable bits.
    wr(A_DIS, 32'h0);
    rd(A_DIS, d);
    check32("disable write", d, 32'h0);
    wr(A_MSK, 32'h0000_ffff);
    rd(A_MSK, d);
    check32("mask write", d, 32'h0000_007f);
    event_in <= 7'h48;
    repeat (5) @(posedge pclk);
    event_in <= 7'h00;
    check1("irq all masked", irq, 1'b0);
    wr(A_MSK, 32'h0000_0040);
    repeat (2) @(posedge pclk);
    check1("irq clip unmasked", irq, 1'b1);
    wr(A_STA, 32'h0000_0008);
    repeat (2) @(posedge pclk);
    check1("irq after clip clear", irq, 1'b0);
    rd(A_STA, d);
    check32("watchdog kept", d, 32'h0000_0040);
    wr(A_DIS, 32'h0000_0040);
    wr(A_MSK, 32'h0);
    repeat (2) @(posedge pclk);
    check1("irq watchdog disabled", irq, 1'b0);
    wr(A_DIS, 32'h0);
    repeat (2) @(posedge pclk);
    check1("irq watchdog enabled", irq, 1'b1);
    wr(A_STA, 32'h0000_007f);
    repeat (2) @(posedge pclk);
    check1("irq all cleared", irq, 1'b0);
    // SAR control fields and the output invert.
    check32("sar pass", {24'h0, sar_data_out}, 32'h0000_005a);
    check32("gain reset", {29'h0, sar_gain_tracking}, 32'h1);
    wr(A_SAR, 32'h0000_d0b4);
    rd(A_SAR, d);
    check32("sar readback", d, 32'h0000_d0b4);
    check1("invert bit", sar_output_invert, 1'b1);
    check32("gain field", {29'h0, sar_gain_tracking}, 32'h5);
    repeat (2) @(posedge pclk);
    check32("sar inverted", {24'h0, sar_data_out}, 32'h0000_00a5);
    // Only the low byte lane is written when just its strobe is set.
    pstrb <= 4'h1;
    wr(A_SAR, 32'h0000_ff00);
    pstrb <= 4'hf;
    rd(A_SAR, d);
    check32("byte lane", d, 32'h0000_d000);
    check1("invert kept", sar_output_invert, 1'b1);
    // An unmapped address is refused with an error and zero data.
    bus(1'b0, 12'h040, 32'h0, d, e);
    check1("unmapped error", e, 1'b1);
    check32("unmapped data", d, 32'h0);
    // With the clock enable low an event is not taken and nothing moves.
    ce <= 1'b0;
    event_in <= 7'h08;
    repeat (5) @(posedge pclk);
    check1("irq frozen", irq, 1'b0);
    ce <= 1'b1;
    event_in <= 7'h00;
    bus(1'b0, A_STA, 32'h0, d, e);
    check32("frozen flags", d, 32'h0);
    check1("mapped no error", e, 1'b0);
    end_of_test;
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    end_of_test;
  end

endmodule
`default_nettype wire
